// File: logic/ltd_decoder.v
// literal, table and add-to-file instruction decode and execute
`timescale 1ns/10ps
`include "ltd_defs.vh"

module ltd_decoder (
    input  wire        clock,              // core clock
    input  wire        reset,              // async reset, active high
    input  wire        clk_en,             // freezes all state when low
    input  wire [15:0] instr_word,         // fetched word, taken in q1
    input  wire        ext_set_en,         // extended instruction set on
    input  wire [7:0]  file_rd_data,       // data memory read value
    input  wire        file_is_port,       // addressed file is a port
    input  wire [7:0]  port_pin_data,      // pin levels of that port
    output reg  [3:0]  phase_ff,           // one-hot q1..q4
    output reg  [7:0]  working_register_ff,    // working register
    output reg  [3:0]  bank_select_register_ff,// bank select bits
    output reg  [11:0] file_pointer_register0_ff, // pointer 0
    output reg  [11:0] file_pointer_register1_ff, // pointer 1
    output reg  [11:0] file_pointer_register2_ff, // pointer 2
    output reg  [15:0] product_ff,         // multiply result
    output reg         neg_flag_ff,        // negative flag
    output reg         overflow_flag_ff,   // overflow flag
    output reg         zero_flag_ff,       // zero flag
    output reg         digit_carry_flag_ff,// digit carry flag
    output reg         carry_flag_ff,      // carry flag
    output reg  [11:0] file_addr_ff,       // data memory address
    output reg         file_rd_ff,         // read strobe, one enabled clock
    output reg         file_wr_ff,         // write strobe, one enabled clock
    output reg  [7:0]  file_wr_data_ff,    // write data
    output reg         tbl_rd_ff,          // table read request
    output reg         tbl_wr_ff,          // table write request
    output reg  [1:0]  tbl_mode_ff,        // none, post+, post-, pre+
    output reg         ret_ff,             // return from subroutine
    output reg         nop_cycle_ff        // cycle runs as no-op
);

    ////////////////////////////////////////////////////////////////////
    // state
    localparam [3:0] ST_Q1 = `LTD_Q1;
    localparam [3:0] ST_Q2 = `LTD_Q2;
    localparam [3:0] ST_Q3 = `LTD_Q3;
    localparam [3:0] ST_Q4 = `LTD_Q4;

    reg [3:0]  nxt_phase;
    reg [3:0]  op_ff;
    // ir_ff keeps the first word across a two-word pointer load
    reg [15:0] ir_ff;
    reg [7:0]  lit2_ff;
    reg [7:0]  opnd_ff;
    reg [1:0]  pend_ff;

    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_dc;
    wire       alu_ov;
    reg  [2:0] alu_fn;

    ////////////////////////////////////////////////////////////////////
    // decode of a fresh word
    function [3:0] dec_op;
        input [15:0] iw;
        begin
            dec_op = `LTD_OP_NOP;
            if (iw[15:8] == `LTD_HI_ADDL) begin
                dec_op = `LTD_OP_ADDL;
            end else if (iw[15:8] == `LTD_HI_ANDL) begin
                dec_op = `LTD_OP_ANDL;
            end else if (iw[15:8] == `LTD_HI_ORL) begin
                dec_op = `LTD_OP_ORL;
            end else if (iw[15:8] == `LTD_HI_XORL) begin
                dec_op = `LTD_OP_XORL;
            end else if (iw[15:8] == `LTD_HI_SUBL) begin
                dec_op = `LTD_OP_SUBL;
            end else if (iw[15:8] == `LTD_HI_MOVL) begin
                dec_op = `LTD_OP_MOVL;
            end else if (iw[15:8] == `LTD_HI_MULL) begin
                dec_op = `LTD_OP_MULL;
            end else if (iw[15:8] == `LTD_HI_RETL) begin
                dec_op = `LTD_OP_RETL;
            end else if (iw[15:4] == `LTD_HI_BANK) begin
                dec_op = `LTD_OP_BANK;
            end else if (iw[15:4] == `LTD_HI_TBL && iw[3]) begin
                dec_op = iw[2] ? `LTD_OP_TABLE_WRITE_OP : `LTD_OP_TABLE_READ_OP;
            end else if (iw[15:6] == `LTD_HI_PTR) begin
                dec_op = `LTD_OP_PTR1;
            end else if (iw[15:10] == `LTD_HI_ADDF) begin
                dec_op = `LTD_OP_ADDF;
            end
        end
    endfunction

    // 12-bit data address of a byte-oriented operand
    // indexed base is pointer 2; the sum wraps inside the 4k space
    function [11:0] file_addr;
        input [7:0]  f;
        input        acc;
        input        ext;
        input [3:0]  bank;
        input [11:0] idx;
        begin
            if (acc) begin
                file_addr = {bank, f};
            end else if (ext && f <= `LTD_IDX_MAX) begin
                file_addr = idx + {4'h0, f};
            end else if (f < `LTD_ACC_SPLIT) begin
                file_addr = {4'h0, f};
            end else begin
                file_addr = {`LTD_ACC_HIGH, f};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // shared arithmetic
    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == 8'h00);
        end
    endfunction

    // widened first so no product bit is lost to the operand width
    function [15:0] mul8;
        input [7:0] a;
        input [7:0] b;
        begin
            mul8 = {8'h00, a} * {8'h00, b};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // arithmetic
    always @* begin
        case (op_ff)
            `LTD_OP_SUBL: alu_fn = `LTD_FN_SUB;
            `LTD_OP_ANDL: alu_fn = `LTD_FN_AND;
            `LTD_OP_ORL:  alu_fn = `LTD_FN_OR;
            `LTD_OP_XORL: alu_fn = `LTD_FN_XOR;
            default:      alu_fn = `LTD_FN_ADD;
        endcase
    end

    ltd_alu u_alu (
        .w_in   (working_register_ff),
        .k_in   (opnd_ff),
        .fn     (alu_fn),
        .res    (alu_res),
        .c_out  (alu_c),
        .dc_out (alu_dc),
        .ov_out (alu_ov)
    );

    ////////////////////////////////////////////////////////////////////
    // phase sequencer
    // a corrupt phase code falls back to q1 instead of locking up
    always @* begin
        case (phase_ff)
            ST_Q1:   nxt_phase = ST_Q2;
            ST_Q2:   nxt_phase = ST_Q3;
            ST_Q3:   nxt_phase = ST_Q4;
            ST_Q4:   nxt_phase = ST_Q1;
            default: nxt_phase = ST_Q1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // execute
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_ff                  <= ST_Q1;
            op_ff                     <= `LTD_OP_NOP;
            ir_ff                     <= 16'h0000;
            lit2_ff                   <= `LTD_RST_BYTE;
            opnd_ff                   <= `LTD_RST_BYTE;
            pend_ff                   <= `LTD_PEND_NONE;
            working_register_ff       <= `LTD_RST_BYTE;
            bank_select_register_ff   <= `LTD_RST_BANK;
            file_pointer_register0_ff <= `LTD_RST_PTR;
            file_pointer_register1_ff <= `LTD_RST_PTR;
            file_pointer_register2_ff <= `LTD_RST_PTR;
            product_ff                <= 16'h0000;
            neg_flag_ff               <= 1'b0;
            overflow_flag_ff          <= 1'b0;
            zero_flag_ff              <= 1'b0;
            digit_carry_flag_ff       <= 1'b0;
            carry_flag_ff             <= 1'b0;
            file_addr_ff              <= `LTD_RST_PTR;
            file_rd_ff                <= 1'b0;
            file_wr_ff                <= 1'b0;
            file_wr_data_ff           <= `LTD_RST_BYTE;
            tbl_rd_ff                 <= 1'b0;
            tbl_wr_ff                 <= 1'b0;
            tbl_mode_ff               <= 2'h0;
            ret_ff                    <= 1'b0;
            nop_cycle_ff              <= 1'b0;
        end else if (clk_en) begin
            phase_ff   <= nxt_phase;
            // strobes last one enabled edge; a stall stretches them too
            file_rd_ff <= 1'b0;
            file_wr_ff <= 1'b0;
            tbl_rd_ff  <= 1'b0;
            tbl_wr_ff  <= 1'b0;
            ret_ff     <= 1'b0;
            case (phase_ff)
                ST_Q1: begin
                    // decode; a pending second cycle consumes the word
                    pend_ff      <= `LTD_PEND_NONE;
                    nop_cycle_ff <= (pend_ff != `LTD_PEND_NONE);
                    if (pend_ff == `LTD_PEND_PTR) begin
                        op_ff   <= `LTD_OP_PTR2;
                        lit2_ff <= instr_word[7:0];
                    end else if (pend_ff == `LTD_PEND_NOP) begin
                        op_ff <= `LTD_OP_NOP;
                    end else if (instr_word[15:12] == `LTD_HI_WORD2) begin
                        // a stray operand word must never execute
                        op_ff <= `LTD_OP_NOP;
                    end else begin
                        op_ff <= dec_op(instr_word);
                        ir_ff <= instr_word;
                    end
                end
                ST_Q2: begin
                    // read operand
                    opnd_ff <= ir_ff[7:0];
                    if (op_ff == `LTD_OP_ADDF) begin
                        file_addr_ff <= file_addr(ir_ff[7:0], ir_ff[8],
                            ext_set_en, bank_select_register_ff,
                            file_pointer_register2_ff);
                        file_rd_ff   <= 1'b1;
                    end
                end
                ST_Q3: begin
                    // process: file operand arrives now
                    if (op_ff == `LTD_OP_ADDF) begin
                        // pins, not the latch, when source is a port
                        opnd_ff <= file_is_port ? port_pin_data
                                                : file_rd_data;
                    end
                end
                ST_Q4: begin
                    // write destination
                    case (op_ff)
                        `LTD_OP_ADDL, `LTD_OP_SUBL: begin
                            working_register_ff <= alu_res;
                            carry_flag_ff       <= alu_c;
                            digit_carry_flag_ff <= alu_dc;
                            overflow_flag_ff    <= alu_ov;
                            zero_flag_ff        <= is_zero(alu_res);
                            neg_flag_ff         <= alu_res[7];
                        end
                        `LTD_OP_ANDL, `LTD_OP_ORL, `LTD_OP_XORL: begin
                            working_register_ff <= alu_res;
                            zero_flag_ff        <= is_zero(alu_res);
                            neg_flag_ff         <= alu_res[7];
                        end
                        `LTD_OP_MOVL: begin
                            working_register_ff <= opnd_ff;
                        end
                        `LTD_OP_BANK: begin
                            // upper literal nibble is ignored
                            bank_select_register_ff <= opnd_ff[3:0];
                        end
                        `LTD_OP_MULL: begin
                            product_ff <= mul8(working_register_ff, opnd_ff);
                        end
                        `LTD_OP_RETL: begin
                            // the word fetched behind a return is stale
                            working_register_ff <= opnd_ff;
                            ret_ff              <= 1'b1;
                            pend_ff             <= `LTD_PEND_NOP;
                        end
                        `LTD_OP_PTR1: begin
                            // second word carries the low literal byte
                            pend_ff <= `LTD_PEND_PTR;
                        end
                        `LTD_OP_PTR2: begin
                            case (ir_ff[5:4])
                                2'h0: file_pointer_register0_ff <=
                                          {ir_ff[3:0], lit2_ff};
                                2'h1: file_pointer_register1_ff <=
                                          {ir_ff[3:0], lit2_ff};
                                2'h2: file_pointer_register2_ff <=
                                          {ir_ff[3:0], lit2_ff};
                                default: ;
                            endcase
                        end
                        `LTD_OP_TABLE_READ_OP: begin
                            // the memory access itself happens outside
                            tbl_rd_ff   <= 1'b1;
                            tbl_mode_ff <= ir_ff[1:0];
                            pend_ff     <= `LTD_PEND_NOP;
                        end
                        `LTD_OP_TABLE_WRITE_OP: begin
                            tbl_wr_ff   <= 1'b1;
                            tbl_mode_ff <= ir_ff[1:0];
                            pend_ff     <= `LTD_PEND_NOP;
                        end
                        `LTD_OP_ADDF: begin
                            // flags follow the sum whichever way it goes
                            carry_flag_ff       <= alu_c;
                            digit_carry_flag_ff <= alu_dc;
                            overflow_flag_ff    <= alu_ov;
                            zero_flag_ff        <= is_zero(alu_res);
                            neg_flag_ff         <= alu_res[7];
                            if (ir_ff[9]) begin
                                file_wr_ff      <= 1'b1;
                                file_wr_data_ff <= alu_res;
                            end else begin
                                working_register_ff <= alu_res;
                            end
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

endmodule

// File: include/ltd_defs.vh
// constants for the literal and table instruction decoder
`ifndef LTD_DEFS_VH
`define LTD_DEFS_VH

// phases of one instruction cycle, one-hot
`define LTD_Q1          4'h1
`define LTD_Q2          4'h2
`define LTD_Q3          4'h4
`define LTD_Q4          4'h8

// decoded operation classes
`define LTD_OP_NOP      4'h0
`define LTD_OP_ADDL     4'h1
`define LTD_OP_ANDL     4'h2
`define LTD_OP_ORL      4'h3
`define LTD_OP_XORL     4'h4
`define LTD_OP_SUBL     4'h5
`define LTD_OP_MOVL     4'h6
`define LTD_OP_BANK     4'h7
`define LTD_OP_MULL     4'h8
`define LTD_OP_RETL     4'h9
`define LTD_OP_PTR1     4'ha
`define LTD_OP_PTR2     4'hb
`define LTD_OP_TABLE_READ_OP    4'hc
`define LTD_OP_TABLE_WRITE_OP    4'hd
`define LTD_OP_ADDF     4'he

// opcode fields
`define LTD_HI_ADDL     8'h0f
`define LTD_HI_ANDL     8'h0b
`define LTD_HI_ORL      8'h09
`define LTD_HI_XORL     8'h0a
`define LTD_HI_SUBL     8'h08
`define LTD_HI_MOVL     8'h0e
`define LTD_HI_MULL     8'h0d
`define LTD_HI_RETL     8'h0c
`define LTD_HI_BANK     12'h010
`define LTD_HI_TBL      12'h000
`define LTD_HI_PTR      10'h3b8
`define LTD_HI_ADDF     6'h09
`define LTD_HI_WORD2    4'hf

// pending second cycle
`define LTD_PEND_NONE   2'h0
`define LTD_PEND_NOP    2'h1
`define LTD_PEND_PTR    2'h2

// alu functions
`define LTD_FN_ADD      3'h0
`define LTD_FN_SUB      3'h1
`define LTD_FN_AND      3'h2
`define LTD_FN_OR       3'h3
`define LTD_FN_XOR      3'h4

// addressing
`define LTD_IDX_MAX     8'h5f
`define LTD_ACC_SPLIT   8'h60
`define LTD_ACC_HIGH    4'hf

// reset values
`define LTD_RST_BYTE    8'h00
`define LTD_RST_PTR     12'h000
`define LTD_RST_BANK    4'h0

`endif

// File: logic/ltd_alu.v
// eight-bit adder and logic unit with carry, digit carry, overflow
`timescale 1ns/10ps
`include "ltd_defs.vh"

module ltd_alu (
    input  wire [7:0] w_in,   // working register value
    input  wire [7:0] k_in,   // literal or file operand
    input  wire [2:0] fn,     // alu function
    output reg  [7:0] res,    // result
    output reg        c_out,  // carry, or not-borrow on subtract
    output reg        dc_out, // carry out of bit 3
    output reg        ov_out  // signed overflow
);

    reg [7:0] b_op;
    reg       cin;
    reg [8:0] sum;
    reg [4:0] nib;

    always @* begin
        // subtract is k + ~w + 1 so carry means no borrow
        b_op   = (fn == `LTD_FN_SUB) ? ~w_in : w_in;
        cin    = (fn == `LTD_FN_SUB);
        sum    = {1'b0, k_in} + {1'b0, b_op} + {8'h00, cin};
        nib    = {1'b0, k_in[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
        c_out  = sum[8];
        dc_out = nib[4];
        ov_out = (k_in[7] == b_op[7]) && (sum[7] != k_in[7]);
        case (fn)
            `LTD_FN_AND: res = k_in & w_in;
            `LTD_FN_OR:  res = k_in | w_in;
            `LTD_FN_XOR: res = k_in ^ w_in;
            default:     res = sum[7:0];
        endcase
    end

endmodule

// File: testbench/ltd_decoder_sva.sv
// concurrent checks on the literal and table decoder ports
`timescale 1ns/10ps
module ltd_decoder_sva (
    input wire        clock,                   // core clock
    input wire        reset,                   // async reset
    input wire        clk_en,                  // advance enable
    input wire [3:0]  phase_ff,                // one-hot phase
    input wire [7:0]  working_register_ff,     // working register
    input wire [3:0]  bank_select_register_ff, // bank select
    input wire        zero_flag_ff,            // zero flag
    input wire        carry_flag_ff,           // carry flag
    input wire [15:0] product_ff,              // product
    input wire        file_rd_ff,              // read strobe
    input wire        file_wr_ff,              // write strobe
    input wire        tbl_rd_ff,               // table read
    input wire        tbl_wr_ff,               // table write
    input wire        ret_ff,                  // return pulse
    input wire        nop_cycle_ff             // forced no-op cycle
);
default clocking cb @(posedge clock); endclocking
default disable iff (reset);
////////////////////////////////////////////////////////////////////////
sequence s_run3;
    clk_en [*3];
endsequence
sequence s_q1_run;
    phase_ff == 4'h1 ##0 s_run3;
endsequence
property p_cycle;
    s_q1_run |=> phase_ff == 4'h8;
endproperty
property p_hold_w;
    !(phase_ff == 4'h8 && clk_en) |=>
        $stable({working_register_ff, zero_flag_ff, carry_flag_ff});
endproperty
property p_hold_bank;
    !(phase_ff == 4'h8 && clk_en) |=>
        $stable({bank_select_register_ff, product_ff});
endproperty
property p_rd_slot;
    file_rd_ff |-> phase_ff == 4'h4;
endproperty
property p_rd_pulse;
    file_rd_ff && clk_en |=> !file_rd_ff;
endproperty
property p_wr_slot;
    file_wr_ff |-> phase_ff == 4'h1 && !file_rd_ff;
endproperty
property p_ret_nop;
    ret_ff && clk_en |=> nop_cycle_ff && !ret_ff;
endproperty
property p_tbl_nop;
    (tbl_rd_ff || tbl_wr_ff) && clk_en |=>
        nop_cycle_ff && !tbl_rd_ff && !tbl_wr_ff;
endproperty
property p_tbl_excl;
    tbl_rd_ff |-> !tbl_wr_ff && phase_ff == 4'h1;
endproperty
property p_nop_w;
    nop_cycle_ff && phase_ff == 4'h8 && clk_en |=>
        $stable(working_register_ff) && !file_wr_ff;
endproperty
property p_freeze;
    !clk_en |=> $stable(phase_ff) && $stable(ret_ff);
endproperty
////////////////////////////////////////////////////////////////////////
a_cycle: assert property (p_cycle)
    else $error("phase did not reach q4");
a_hold_w: assert property (p_hold_w)
    else $error("working register moved outside q4");
a_hold_bank: assert property (p_hold_bank)
    else $error("bank or product moved outside q4");
a_rd_slot: assert property (p_rd_slot)
    else $error("file read outside operand phase");
a_rd_pulse: assert property (p_rd_pulse)
    else $error("file read strobe too long");
a_wr_slot: assert property (p_wr_slot)
    else $error("file write at wrong phase");
a_ret_nop: assert property (p_ret_nop)
    else $error("return not followed by no-op cycle");
a_tbl_nop: assert property (p_tbl_nop)
    else $error("table op not followed by no-op cycle");
a_tbl_excl: assert property (p_tbl_excl)
    else $error("table read and write together");
a_nop_w: assert property (p_nop_w)
    else $error("no-op cycle changed state");
a_freeze: assert property (p_freeze)
    else $error("state moved while frozen");
endmodule
bind ltd_decoder ltd_decoder_sva u_sva (.clock, .reset, .clk_en,
    .phase_ff, .working_register_ff, .bank_select_register_ff,
    .zero_flag_ff, .carry_flag_ff, .product_ff, .file_rd_ff, .file_wr_ff,
    .tbl_rd_ff, .tbl_wr_ff, .ret_ff, .nop_cycle_ff);

// File: testbench/ltd_decoder_tb_top.sv
// self-checking bench for the literal and table decoder
`timescale 1ns/10ps
module ltd_decoder_tb_top;
reg         clock, reset, clk_en, ext_set_en, file_is_port;
reg  [15:0] instr_word;
reg  [7:0]  file_rd_data, port_pin_data;
wire [3:0]  phase_ff, bank_select_register_ff;
wire [7:0]  working_register_ff, file_wr_data_ff;
wire [11:0] file_pointer_register0_ff, file_pointer_register1_ff;
wire [11:0] file_pointer_register2_ff, file_addr_ff;
wire [15:0] product_ff;
wire        neg_flag_ff, overflow_flag_ff, zero_flag_ff;
wire        digit_carry_flag_ff, carry_flag_ff, file_rd_ff, file_wr_ff;
wire        tbl_rd_ff, tbl_wr_ff, ret_ff, nop_cycle_ff;
wire [1:0]  tbl_mode_ff;
wire [4:0]  flags = {neg_flag_ff, overflow_flag_ff, zero_flag_ff,
                     digit_carry_flag_ff, carry_flag_ff};
wire [35:0] ptrs = {file_pointer_register2_ff,
                    file_pointer_register1_ff, file_pointer_register0_ff};
integer     n_errors, compares, i, j;
reg  [31:0] rn;
reg  [7:0]  m_w, k, f;
reg  [4:0]  m_fl;
reg  [3:0]  m_bank;
reg  [11:0] m_ptr [0:2];
reg  [11:0] ea;
reg  [12:0] e;
reg         s_nop, s_rd, d, a;
reg  [95:0] hand = 96'h0e10_0f15_0e80_0f80_0e00_0800;
reg  [27:0] ops = 28'hfb9a8ed;

ltd_decoder uut (.clock, .reset, .clk_en, .instr_word, .ext_set_en,
    .file_rd_data, .file_is_port, .port_pin_data, .phase_ff,
    .working_register_ff, .bank_select_register_ff,
    .file_pointer_register0_ff, .file_pointer_register1_ff,
    .file_pointer_register2_ff, .product_ff, .neg_flag_ff,
    .overflow_flag_ff, .zero_flag_ff, .digit_carry_flag_ff,
    .carry_flag_ff, .file_addr_ff, .file_rd_ff, .file_wr_ff,
    .file_wr_data_ff, .tbl_rd_ff, .tbl_wr_ff, .tbl_mode_ff, .ret_ff,
    .nop_cycle_ff);

initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
end
////////////////////////////////////////////////////////////////////////
// expected {result, n, ov, z, dc, c}; subtract carry means no borrow
function [12:0] ref_alu(input [3:0] op, input [7:0] w, input [7:0] k,
                        input [4:0] fl);
    reg [8:0] s;
    reg [4:0] h;
    reg [7:0] r;
    reg       sb, v;
    begin
        sb = (op == 4'h8);
        s = {1'b0, k} + (sb ? {1'b0, ~w} + 9'h1 : {1'b0, w});
        h = {1'b0, k[3:0]} + (sb ? {1'b0, ~w[3:0]} + 5'h1 : {1'b0, w[3:0]});
        r = s[7:0];
        v = ((sb ? ~w[7] : w[7]) == k[7]) && (r[7] != k[7]);
        ref_alu = {r, r[7], v, r == 8'h0, h[4], s[8]};
        case (op)
            4'hb: r = w & k;
            4'h9: r = w | k;
            4'ha: r = w ^ k;
            4'hf, 4'h8: r = s[7:0];
            default: r = w;
        endcase
        if (op == 4'hb || op == 4'h9 || op == 4'ha)
            ref_alu = {r, r[7], fl[3], r == 8'h0, fl[1], fl[0]};
        else if (op != 4'hf && !sb)
            ref_alu = {w, fl};
    end
endfunction

task chk_val(input [15:0] got, input [15:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    end
endtask

task chk_flags(input [4:0] got, input [4:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: flags %b expected %b", $time, got, exp);
        end
    end
endtask

task results;
    begin
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
endtask

// one instruction cycle; random stalls keep the count of enabled edges
task run(input [15:0] wd);
    integer n, t;
    reg     en;
    begin
        n = 0;
        chk_val({12'h0, phase_ff}, 16'h1);
        instr_word = wd;
        for (t = 0; t < 40 && n < 4; t = t + 1) begin
            en = ($urandom % 5) != 0;
            clk_en = en;
            @(negedge clock);
            if (en) begin
                n = n + 1;
                if (n == 1) s_nop = nop_cycle_ff;
                if (n == 2) s_rd = file_rd_ff;
            end
        end
        if (n < 4) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: instruction cycle stuck", $time);
            results;
        end
    end
endtask

task lit(input [15:0] wd);
    reg [15:0] p;
    begin
        p = {8'h0, m_w} * {8'h0, wd[7:0]};
        e = ref_alu(wd[11:8], m_w, wd[7:0], m_fl);
        if (wd[11:8] == 4'he) e[12:5] = wd[7:0];
        run(wd);
        chk_val(working_register_ff, e[12:5]);
        chk_flags(flags, e[4:0]);
        if (wd[11:8] == 4'hd) chk_val(product_ff, p);
        m_w = e[12:5];
        m_fl = e[4:0];
    end
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    n_errors = 0;
    compares = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    instr_word = 16'h0;
    ext_set_en = 1'b0;
    file_is_port = 1'b0;
    file_rd_data = 8'h0;
    port_pin_data = 8'h0;
    {m_w, m_fl, m_bank} = 17'h0;
    for (i = 0; i < 3; i = i + 1) m_ptr[i] = 12'h0;
    rn = $urandom(32'h5644f9e5);
    repeat (20) @(negedge clock);
    reset = 1'b0;
    for (i = 0; i < 66; i = i + 1) begin
        rn = $urandom;
        j = rn[10:8] % 7;
        k = rn[12:11] == 2'h0 ? {~rn[0], {7{rn[0]}}} : rn[7:0];
        lit(i < 6 ? hand[(5 - i) * 16 +: 16] : {4'h0, ops[j * 4 +: 4], k});
    end
    $display("test literal done");
    for (i = 0; i < 4; i = i + 1) begin
        rn = $urandom;
        m_bank = i == 0 ? 4'hf : rn[3:0];
        run({12'h010, m_bank});
        chk_val(bank_select_register_ff, m_bank);
        chk_flags(flags, m_fl);
    end
    rn = $urandom;
    run({8'h0c, rn[7:0]});
    chk_val(ret_ff, 16'h1);
    chk_val(working_register_ff, rn[7:0]);
    run(16'h0e5a);
    chk_val(s_nop, 16'h1);
    chk_val(working_register_ff, rn[7:0]);
    m_w = rn[7:0];
    $display("test return done");
    for (i = 0; i < 3; i = i + 1) begin
        rn = $urandom;
        run({10'h3b8, i[1:0], rn[11:8]});
        run({8'hf0, rn[7:0]});
        m_ptr[i] = rn[11:0];
        chk_val(ptrs[i * 12 +: 12], m_ptr[i]);
        chk_flags(flags, m_fl);
    end
    run(16'hf3c5);
    chk_val(working_register_ff, m_w);
    chk_val(ptrs[35:24], m_ptr[2]);
    $display("test pointer done");
    for (i = 8; i < 16; i = i + 1) begin
        run({12'h000, i[3:0]});
        chk_val(tbl_rd_ff, {15'h0, i < 12});
        chk_val(tbl_wr_ff, {15'h0, i > 11});
        chk_val(tbl_mode_ff, i[1:0]);
        run(16'h0e33);
        chk_val(s_nop, 16'h1);
        chk_val(working_register_ff, m_w);
    end
    $display("test table done");
    for (i = 0; i < 24; i = i + 1) begin
        rn = $urandom;
        {d, a, ext_set_en, file_is_port} = rn[3:0];
        f = (i % 3 == 0) ? 8'h5f + {7'h0, i[0]} : rn[11:4];
        file_rd_data = rn[19:12];
        port_pin_data = rn[27:20];
        k = file_is_port ? port_pin_data : file_rd_data;
        ea = a ? {m_bank, f} : (ext_set_en && f <= 8'h5f) ?
             m_ptr[2] + {4'h0, f} : (f < 8'h60 ? {4'h0, f} : {4'hf, f});
        e = ref_alu(4'hf, m_w, k, m_fl);
        run({6'h09, d, a, f});
        chk_val(s_rd, 16'h1);
        chk_val(file_addr_ff, ea);
        chk_val(file_wr_ff, {15'h0, d});
        if (d) chk_val(file_wr_data_ff, e[12:5]);
        else m_w = e[12:5];
        chk_val(working_register_ff, m_w);
        chk_flags(flags, e[4:0]);
        m_fl = e[4:0];
    end
    $display("test add_file done");
    results;
end
endmodule
